//--- hw/csf_status_flags.sv
`timescale 1ns/10ps
`default_nettype none
module csf_status_flags
    import csf_pkg::*;
#(
    parameter int ADDR_W = CSF_ADDR_W
)
(
    // Clock, reset, enable
    input wire logic clock_i,
    input wire logic reset_n_i,
    input wire logic clk_en_i,
    // Instruction execution
    input wire logic exec_valid_i,
    input wire csf_exec_t exec_i,
    input wire logic watchdog_timeout_i,
    // Register read port
    input wire logic rd_en_i,
    input wire logic [ADDR_W-1:0] rd_addr_i,
    // Address formation
    input wire logic [CSF_BANK_W-1:0] file_addr_i,
    input wire logic [7:0] pointer_i,
    // Outputs
    output logic [7:0] flags_o,
    output logic [7:0] result_o,
    output logic result_valid_o,
    output logic result_to_file_o,
    output logic [7:0] rd_data_o,
    output logic rd_hit_o,
    output logic [ADDR_W-1:0] direct_addr_o,
    output logic [ADDR_W-1:0] indirect_addr_o
);

    if (ADDR_W != CSF_ADDR_W)
    begin : g_bad_width
        $error("csf_status_flags: only a 9-bit data address is served");
    end

    csf_state_t s;
    csf_state_t next_s;

    logic [8:0] sum;
    logic [4:0] nib;
    logic [7:0] add_x;
    logic [7:0] add_y;
    logic add_cin;
    logic [7:0] res;
    logic [7:0] affected;
    logic [7:0] calc;
    logic writes_file;
    logic hit_write;
    logic [7:0] flags;

    // Same register in every bank: only the in-bank offset is decoded
    function automatic logic is_flags_addr(input logic [ADDR_W-1:0] a);
        is_flags_addr = (a[CSF_BANK_W-1:0] == CSF_REG_OFFSET);
    endfunction

    always_comb
    begin
        next_s = s;
        res = exec_i.operand;
        affected = CSF_MASK_NONE;
        writes_file = exec_i.to_file;
        calc = s.flags;

        // Subtraction is an add of the two's complement, so carry
        // out means no borrow
        if (exec_i.op == CSF_OP_SUB_FROM_LITERAL ||
            exec_i.op == CSF_OP_SUB_ACCUM_FROM_FILE)
        begin
            add_x = exec_i.operand;
            add_y = ~exec_i.accum;
            add_cin = 1'b1;
        end
        else
        begin
            add_x = exec_i.operand;
            add_y = exec_i.accum;
            add_cin = 1'b0;
        end
        sum = {1'b0, add_x} + {1'b0, add_y} + {8'h00, add_cin};
        nib = {1'b0, add_x[3:0]} + {1'b0, add_y[3:0]} + {4'h0, add_cin};

        case (exec_i.op)
            CSF_OP_ADD_ACCUM_FILE, CSF_OP_ADD_LITERAL,
            CSF_OP_SUB_FROM_LITERAL, CSF_OP_SUB_ACCUM_FROM_FILE:
            begin
                res = sum[7:0];
                affected = CSF_MASK_ARITH;
                calc[CSF_BIT_CARRY] = sum[8];
                calc[CSF_BIT_DIGIT] = nib[4];
            end
            CSF_OP_AND:
            begin
                res = exec_i.operand & exec_i.accum;
                affected = CSF_MASK_ZERO;
            end
            CSF_OP_OR:
            begin
                res = exec_i.operand | exec_i.accum;
                affected = CSF_MASK_ZERO;
            end
            CSF_OP_XOR:
            begin
                res = exec_i.operand ^ exec_i.accum;
                affected = CSF_MASK_ZERO;
            end
            CSF_OP_INCREMENT:
            begin
                res = exec_i.operand + 8'h01;
                affected = CSF_MASK_ZERO;
            end
            CSF_OP_DECREMENT:
            begin
                res = exec_i.operand - 8'h01;
                affected = CSF_MASK_ZERO;
            end
            CSF_OP_COMPLEMENT:
            begin
                res = ~exec_i.operand;
                affected = CSF_MASK_ZERO;
            end
            CSF_OP_MOVE_FILE:
            begin
                res = exec_i.operand;
                affected = CSF_MASK_ZERO;
            end
            CSF_OP_ROTATE_LEFT:
            begin
                res = {exec_i.operand[6:0], s.flags[CSF_BIT_CARRY]};
                affected = CSF_MASK_CARRY;
                calc[CSF_BIT_CARRY] = exec_i.operand[7];
            end
            CSF_OP_ROTATE_RIGHT:
            begin
                res = {s.flags[CSF_BIT_CARRY], exec_i.operand[7:1]};
                affected = CSF_MASK_CARRY;
                calc[CSF_BIT_CARRY] = exec_i.operand[0];
            end
            CSF_OP_CLEAR_FILE:
            begin
                res = 8'h00;
                affected = CSF_MASK_ZERO;
                writes_file = 1'b1;
            end
            CSF_OP_BIT_CLEAR:
            begin
                res = exec_i.operand;
                res[exec_i.bit_sel] = 1'b0;
                writes_file = 1'b1;
            end
            CSF_OP_BIT_SET:
            begin
                res = exec_i.operand;
                res[exec_i.bit_sel] = 1'b1;
                writes_file = 1'b1;
            end
            CSF_OP_NIBBLE_EXCHANGE:
            begin
                res = {exec_i.operand[3:0], exec_i.operand[7:4]};
            end
            CSF_OP_MOVE_ACCUM_TO_FILE:
            begin
                res = exec_i.accum;
                writes_file = 1'b1;
            end
            CSF_OP_NOP, CSF_OP_WATCHDOG_KICK, CSF_OP_SLEEP:
            begin
                writes_file = 1'b0;
            end
            default:
            begin
                writes_file = 1'b0;
            end
        endcase

        if (affected[CSF_BIT_ZERO])
        begin
            calc[CSF_BIT_ZERO] = (res == 8'h00);
        end

        hit_write = exec_valid_i && writes_file &&
                    is_flags_addr(exec_i.dest_addr);
        flags = s.flags;
        if (hit_write)
        begin
            // Reset-cause flags are not software writable
            flags = (res & ~CSF_MASK_RESET_SRC) |
                    (s.flags & CSF_MASK_RESET_SRC);
            // A flag-computing op locks all three arith bits, so a
            // clear keeps carry and digit carry
            if (affected != CSF_MASK_NONE)
            begin
                flags = (flags & ~CSF_MASK_ARITH) |
                        (s.flags & CSF_MASK_ARITH);
            end
        end
        if (exec_valid_i)
        begin
            // Computed flags override written data
            flags = (flags & ~affected) | (calc & affected);
            if (exec_i.op == CSF_OP_WATCHDOG_KICK)
            begin
                flags[CSF_BIT_EXPIRY] = 1'b1;
                flags[CSF_BIT_LOW_POWER] = 1'b1;
            end
            else if (exec_i.op == CSF_OP_SLEEP)
            begin
                flags[CSF_BIT_EXPIRY] = 1'b1;
                flags[CSF_BIT_LOW_POWER] = 1'b0;
            end
        end
        // Time-out is the hardware event and wins over a kick
        if (watchdog_timeout_i)
        begin
            flags[CSF_BIT_EXPIRY] = 1'b0;
        end
        next_s.flags = flags;

        next_s.result = res;
        next_s.result_valid = exec_valid_i &&
                              exec_i.op != CSF_OP_NOP &&
                              exec_i.op != CSF_OP_WATCHDOG_KICK &&
                              exec_i.op != CSF_OP_SLEEP;
        next_s.result_to_file = exec_valid_i && writes_file;

        // Read returns the value before this cycle's update
        next_s.rd_hit = rd_en_i && is_flags_addr(rd_addr_i);
        next_s.rd_data = next_s.rd_hit ? s.flags : 8'h00;

        // Bank bits as they stand when the address is formed
        next_s.direct_addr = {s.flags[CSF_BIT_PAGE_HI],
                              s.flags[CSF_BIT_PAGE_LO],
                              file_addr_i};
        next_s.indirect_addr = {s.flags[CSF_BIT_IND_PAGE],
                                pointer_i};
    end

    always_ff @(posedge clock_i)
    begin
        if (!reset_n_i)
        begin
            s <= '0;
            s.flags <= CSF_RESET_VALUE;
        end
        else if (clk_en_i)
        begin
            s <= next_s;
        end
    end

    assign flags_o = s.flags;
    assign result_o = s.result;
    assign result_valid_o = s.result_valid;
    assign result_to_file_o = s.result_to_file;
    assign rd_data_o = s.rd_data;
    assign rd_hit_o = s.rd_hit;
    assign direct_addr_o = s.direct_addr;
    assign indirect_addr_o = s.indirect_addr;

endmodule
`default_nettype wire

//--- hw/csf_pkg.sv
// What this block does
// - The flags register may be the destination of any instruction, like any other data register.
// - An instruction that updates the zero, digit-carry or carry flags ignores written data for those bits and keeps the computed flags.
// - The time-out and power-down flags ignore all software writes and change only through reset and sleep/watchdog events.
// - Clearing the flags register clears the three bank bits and sets the zero flag, leaving 000u u1uu.
// - Bit clear, bit set, nibble swap and accumulator move leave the three arithmetic flags alone, and software should use only these on it.
// - In subtraction carry and digit carry are active-low borrows, the subtraction being an add of the two's complement.
// - Bit 7 picks banks 2 and 3 (from 100h) for indirect addressing when 1, banks 0 and 1 when 0.
// - The time-out flag is 1 after power-up, watchdog kick or sleep, and 0 after a watchdog time-out.
// - One physical register answers at 03h, 83h, 103h and 183h.
package csf_pkg;

    // Register location within any bank
    localparam logic [6:0] CSF_REG_OFFSET = 7'h03;
    localparam int CSF_ADDR_W = 9;
    localparam int CSF_BANK_W = 7;

    // Field positions
    localparam int CSF_BIT_CARRY = 0;
    localparam int CSF_BIT_DIGIT = 1;
    localparam int CSF_BIT_ZERO = 2;
    localparam int CSF_BIT_LOW_POWER = 3;
    localparam int CSF_BIT_EXPIRY = 4;
    localparam int CSF_BIT_PAGE_LO = 5;
    localparam int CSF_BIT_PAGE_HI = 6;
    localparam int CSF_BIT_IND_PAGE = 7;

    // Masks
    localparam logic [7:0] CSF_MASK_ARITH = 8'h07;
    localparam logic [7:0] CSF_MASK_ZERO = 8'h04;
    localparam logic [7:0] CSF_MASK_CARRY = 8'h01;
    localparam logic [7:0] CSF_MASK_NONE = 8'h00;
    localparam logic [7:0] CSF_MASK_RESET_SRC = 8'h18;

    // Power-up value: banks 0, both reset-cause flags 1, arith flags 0
    localparam logic [7:0] CSF_RESET_VALUE = 8'h18;

    typedef enum logic [4:0] {
        CSF_OP_NOP,
        CSF_OP_ADD_ACCUM_FILE,
        CSF_OP_ADD_LITERAL,
        CSF_OP_SUB_FROM_LITERAL,
        CSF_OP_SUB_ACCUM_FROM_FILE,
        CSF_OP_AND,
        CSF_OP_OR,
        CSF_OP_XOR,
        CSF_OP_INCREMENT,
        CSF_OP_DECREMENT,
        CSF_OP_COMPLEMENT,
        CSF_OP_MOVE_FILE,
        CSF_OP_ROTATE_LEFT,
        CSF_OP_ROTATE_RIGHT,
        CSF_OP_CLEAR_FILE,
        CSF_OP_BIT_CLEAR,
        CSF_OP_BIT_SET,
        CSF_OP_NIBBLE_EXCHANGE,
        CSF_OP_MOVE_ACCUM_TO_FILE,
        CSF_OP_WATCHDOG_KICK,
        CSF_OP_SLEEP
    } csf_op_t;

    typedef struct packed {
        csf_op_t op;
        logic [7:0] accum;
        logic [7:0] operand;
        logic [2:0] bit_sel;
        logic to_file;
        logic [CSF_ADDR_W-1:0] dest_addr;
    } csf_exec_t;

    typedef struct packed {
        logic [7:0] flags;
        logic [7:0] result;
        logic result_valid;
        logic result_to_file;
        logic [7:0] rd_data;
        logic rd_hit;
        logic [CSF_ADDR_W-1:0] direct_addr;
        logic [CSF_ADDR_W-1:0] indirect_addr;
    } csf_state_t;

endpackage

//--- tb/csf_status_flags_checker.sv
`timescale 1ns/10ps
`default_nettype none
module csf_status_flags_checker
    import csf_pkg::*;
(
    // Block inputs
    input wire logic clock_i,
    input wire logic reset_n_i,
    input wire logic clk_en_i,
    input wire logic exec_valid_i,
    input wire csf_exec_t exec_i,
    input wire logic watchdog_timeout_i,
    input wire logic rd_en_i,
    input wire logic [CSF_ADDR_W-1:0] rd_addr_i,
    input wire logic [CSF_BANK_W-1:0] file_addr_i,
    input wire logic [7:0] pointer_i,
    // Block outputs
    input wire logic [7:0] flags_o,
    input wire logic [7:0] rd_data_o,
    input wire logic rd_hit_o,
    input wire logic [CSF_ADDR_W-1:0] direct_addr_o,
    input wire logic [CSF_ADDR_W-1:0] indirect_addr_o
);
    wire logic ev = reset_n_i && clk_en_i && exec_valid_i;
    wire logic st = exec_i.dest_addr[6:0] == CSF_REG_OFFSET;
    wire logic kick = exec_i.op == CSF_OP_WATCHDOG_KICK;
    wire logic hit_addr = rd_addr_i[6:0] == CSF_REG_OFFSET;
    wire logic [8:0] sum = exec_i.accum + exec_i.operand;
    wire logic [4:0] nib = exec_i.accum[3:0] + exec_i.operand[3:0];
    wire logic [2:0] add_f = {sum[7:0] == 8'h00, nib[4], sum[8]};
    // Carry bits read as no-borrow in subtraction
    wire logic [2:0] sub_f = {exec_i.operand == exec_i.accum,
        exec_i.operand[3:0] >= exec_i.accum[3:0],
        exec_i.operand >= exec_i.accum};

    default clocking @(posedge clock_i); endclocking
    default disable iff (!reset_n_i);

    a_cause_flags_locked: assert property (
        !(ev && (kick || exec_i.op == CSF_OP_SLEEP)) && !watchdog_timeout_i
        |=> flags_o[4:3] == $past(flags_o[4:3]))
        else $error("reset cause flags moved");
    a_kick_sleep_flags: assert property (
        ev && (kick || exec_i.op == CSF_OP_SLEEP) && !watchdog_timeout_i
        |=> flags_o[4] && flags_o[3] == $past(kick))
        else $error("kick or sleep flags wrong");
    a_clear_status: assert property (
        ev && exec_i.op == CSF_OP_CLEAR_FILE && st |=> flags_o[7:5] == 3'h0
        && flags_o[2] && flags_o[1:0] == $past(flags_o[1:0]))
        else $error("clear pattern wrong");
    a_safe_ops_keep: assert property (
        ev && !st && exec_i.op inside {CSF_OP_BIT_CLEAR, CSF_OP_BIT_SET,
        CSF_OP_NIBBLE_EXCHANGE, CSF_OP_MOVE_ACCUM_TO_FILE}
        |=> flags_o[2:0] == $past(flags_o[2:0]))
        else $error("arith flags moved");
    a_add_flags: assert property (
        ev && exec_i.op inside {CSF_OP_ADD_LITERAL, CSF_OP_ADD_ACCUM_FILE}
        |=> flags_o[2:0] == $past(add_f))
        else $error("add flags wrong");
    a_sub_borrow: assert property (
        ev && exec_i.op inside {CSF_OP_SUB_FROM_LITERAL,
        CSF_OP_SUB_ACCUM_FROM_FILE} |=> flags_o[2:0] == $past(sub_f))
        else $error("sub flags wrong");
    a_status_read: assert property (
        clk_en_i && rd_en_i |=> rd_hit_o == $past(hit_addr) && rd_data_o
        == ($past(hit_addr) ? $past(flags_o) : 8'h00))
        else $error("read answer wrong");
    a_page_addr: assert property (
        clk_en_i |=> direct_addr_o == {$past(flags_o[6:5]), $past(file_addr_i)}
        && indirect_addr_o == {$past(flags_o[7]), $past(pointer_i)})
        else $error("bank address wrong");
endmodule
bind csf_status_flags csf_status_flags_checker i_csf_status_flags_checker (
    .clock_i, .reset_n_i, .clk_en_i, .exec_valid_i, .exec_i,
    .watchdog_timeout_i, .rd_en_i, .rd_addr_i, .file_addr_i, .pointer_i,
    .flags_o, .rd_data_o, .rd_hit_o, .direct_addr_o, .indirect_addr_o
);
`default_nettype wire

//--- tb/csf_core_model.sv
`timescale 1ns/10ps
`default_nettype none
module csf_core_model
    import csf_pkg::*;
(
    // Instruction issue
    input wire logic clock_i,
    output var logic exec_valid_o,
    output var csf_exec_t exec_o
);
    initial
    begin
        exec_valid_o = 1'b0;
        exec_o = '0;
    end
    // Any op may name the flags register as destination
    task issue(input csf_op_t op, input logic [7:0] a, b,
               input logic [2:0] bs, input logic [8:0] dst);
        exec_o = '{op, a, b, bs, 1'b1, dst};
        exec_valid_o = 1'b1;
        @(posedge clock_i);
        #1;
    endtask
    // Scrambled so a block reading idle fields cannot pass by luck
    task idle();
        exec_valid_o = 1'b0;
        exec_o = csf_exec_t'(~exec_o);
    endtask
endmodule
`default_nettype wire

//--- tb/test_csf_status_flags.sv
`timescale 1ns/10ps
`default_nettype none
module test_csf_status_flags
    import csf_pkg::*;
();
    logic clock, reset_n, wd_timeout, rd_en, exec_valid, rd_hit;
    logic res_valid, res_to_file;
    logic [7:0] alu_result;
    logic [8:0] rd_addr, direct_addr, indirect_addr;
    logic [6:0] file_addr;
    logic [7:0] pointer, flags, rd_data;
    csf_exec_t exec;
    int bad_count = 0;
    int samples_checked = 0;

    csf_core_model i_csf_core_model (.clock_i(clock),
        .exec_valid_o(exec_valid), .exec_o(exec));
    csf_status_flags i_csf_status_flags (.clock_i(clock), .reset_n_i(reset_n),
        .clk_en_i(1'b1), .exec_valid_i(exec_valid), .exec_i(exec),
        .watchdog_timeout_i(wd_timeout), .rd_en_i(rd_en), .rd_addr_i(rd_addr),
        .file_addr_i(file_addr), .pointer_i(pointer), .flags_o(flags),
        .result_o(alu_result), .result_valid_o(res_valid),
        .result_to_file_o(res_to_file),
        .rd_data_o(rd_data), .rd_hit_o(rd_hit), .direct_addr_o(direct_addr),
        .indirect_addr_o(indirect_addr));

    initial
    begin
        clock = 1'b0;
        forever #2.5 clock = ~clock;
    end
    task chk(input string name, input logic [8:0] seen, exp);
        samples_checked++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("BAD %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task step();
        @(posedge clock);
        #1;
    endtask
    task rest();
        i_csf_core_model.idle();
        step();
    endtask
    task t_reset();
        chk("flags", flags, 9'h018);
        step();
        chk("direct", direct_addr, 9'h011);
        chk("indirect", indirect_addr, 9'h022);
    endtask
    task t_write();
        i_csf_core_model.issue(CSF_OP_MOVE_ACCUM_TO_FILE, 8'he7, 0, 0, 9'h003);
        chk("moved", flags, 9'h0ff);
        i_csf_core_model.issue(CSF_OP_CLEAR_FILE, 0, flags, 0, 9'h183);
        chk("cleared", flags, 9'h01f);
        chk("clear result", alu_result, 9'h000);
        chk("clear pulses", {res_valid, res_to_file}, 9'h003);
    endtask
    task t_arith();
        i_csf_core_model.issue(CSF_OP_ADD_LITERAL, 8'h0f, 8'h01, 0, 9'h020);
        chk("add", flags[2:0], 9'h2);
        chk("add result", alu_result, 9'h010);
        i_csf_core_model.issue(CSF_OP_SUB_FROM_LITERAL, 8'h01, 8'h10, 0,
                               9'h020);
        chk("sub nibble", flags[2:0], 9'h1);
        i_csf_core_model.issue(CSF_OP_SUB_ACCUM_FROM_FILE, 8'h01, 0, 0,
                               9'h020);
        chk("sub under", flags[2:0], 9'h0);
        i_csf_core_model.issue(CSF_OP_ADD_LITERAL, 8'h01, 8'h01, 0, 9'h103);
        chk("add to reg", flags, 9'h018);
        i_csf_core_model.issue(CSF_OP_AND, 8'hf0, 8'h0f, 0, 9'h020);
        chk("and zero", flags[2:0], 9'h4);
        i_csf_core_model.issue(CSF_OP_ROTATE_LEFT, 0, 8'h83, 0, 9'h083);
        chk("rotate to reg", flags, 9'h01d);
        chk("rotate result", alu_result, 9'h006);
    endtask
    task t_bank();
        i_csf_core_model.issue(CSF_OP_ADD_ACCUM_FILE, 8'hff, 8'h01, 0, 9'h020);
        chk("add wrap", flags[2:0], 9'h7);
        i_csf_core_model.issue(CSF_OP_BIT_SET, 0, flags, 3'h5, 9'h083);
        i_csf_core_model.issue(CSF_OP_BIT_SET, 0, flags, 3'h7, 9'h003);
        i_csf_core_model.issue(CSF_OP_NIBBLE_EXCHANGE, 0, 8'h5a, 0, 9'h020);
        chk("bits set", flags, 9'h0bf);
        rest();
        chk("direct", direct_addr, 9'h091);
        chk("indirect", indirect_addr, 9'h122);
    endtask
    task t_watch();
        i_csf_core_model.issue(CSF_OP_SLEEP, 0, 0, 0, 9'h000);
        chk("sleep", flags[4:3], 9'h2);
        i_csf_core_model.issue(CSF_OP_WATCHDOG_KICK, 0, 0, 0, 9'h000);
        chk("kick", flags[4:3], 9'h3);
        chk("kick pulses", {res_valid, res_to_file}, 9'h000);
        wd_timeout = 1'b1;
        i_csf_core_model.issue(CSF_OP_WATCHDOG_KICK, 0, 0, 0, 9'h000);
        wd_timeout = 1'b0;
        chk("expired", flags[4:3], 9'h1);
        rest();
    endtask
    task t_read();
        rd_en = 1'b1;
        for (int i = 0; i < 4; i++)
        begin
            rd_addr = {i[1:0], 7'h03};
            step();
            chk("mirror", {rd_hit, rd_data}, 9'h1af);
        end
        rd_addr = 9'h104;
        step();
        chk("unmapped", {rd_hit, rd_data}, 9'h000);
        rd_en = 1'b0;
    endtask
    task results();
        $display("compared %0d mismatched %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    initial
    begin
        #5000;
        bad_count++;
        results();
    end
    initial
    begin
        reset_n = 1'b0;
        wd_timeout = 1'b0;
        rd_en = 1'b0;
        rd_addr = 9'h000;
        file_addr = 7'h11;
        pointer = 8'h22;
        repeat (8) @(posedge clock);
        #1;
        reset_n = 1'b1;
        t_reset();
        t_write();
        t_arith();
        t_bank();
        t_watch();
        t_read();
        results();
    end
endmodule
`default_nettype wire
